// ===== sync_serial_defs.svh
`ifndef SYNC_SERIAL_DEFS_SVH
`define SYNC_SERIAL_DEFS_SVH

// register byte offsets
`define OFF_MODE 8'h00
`define OFF_CTRL0 8'h04
`define OFF_CTRL1 8'h08
`define OFF_TXBUF 8'h0C
`define OFF_RXBUF 8'h10
`define OFF_SMR3 8'h14
`define OFF_BAUD 8'h18
`define OFF_CLKSYNC 8'h1C

// register indexes used by the decoder
`define IDX_MODE 4'h0
`define IDX_CTRL0 4'h1
`define IDX_CTRL1 4'h2
`define IDX_TXBUF 4'h3
`define IDX_RXBUF 4'h4
`define IDX_SMR3 4'h5
`define IDX_BAUD 4'h6
`define IDX_CLKSYNC 4'h7
`define IDX_NONE 4'hF

// mode register fields
`define MODE_SEL_LSB 0
`define MODE_CLKDIR_BIT 3
`define MODE_CLKSYNC 3'h1

// control register zero fields
`define C0_TXEMPTY_BIT 3
`define C0_HSDIS_BIT 4
`define C0_POL_BIT 6
`define C0_ORDER_BIT 7

// control register one fields
`define C1_TE_BIT 0
`define C1_TBE_BIT 1
`define C1_RE_BIT 2
`define C1_RXF_BIT 3
`define C1_IRQSRC_BIT 4
`define C1_CLKSTOP_BIT 5

// receive buffer and special mode three fields
`define RB_OVR_BIT 12
`define S3_SSE_BIT 0
`define S3_PHASE_BIT 1
`define S3_ROLE_BIT 3
`define S3_ERR_BIT 5

// clock synchronisation register fields
`define CS_HALVE_BIT 0
`define CS_SYNC_BIT 1

// frame timing
`define FRAME_BITS 4'h8
`define OVR_CHECK_BIT 4'h6
`define IDLE_FILL 8'hFF

`endif

// ===== sync_serial_pkg.sv
package sync_serial_pkg;

	// synchronised pin inputs
	typedef struct packed {
		logic sclk;
		logic sel_n;
		logic trig_n;
		logic mrx;
		logic srx;
	} pin_in_t;

	typedef struct packed {
		pin_in_t meta;
		pin_in_t stable;
	} sync_state_t;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_RUN = 2'b01
	} eng_state_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic [2:0] mode_sel;
		logic clk_dir;
		logic hs_dis;
		logic pol;
		logic msb_first;
		logic te;
		logic tbe;
		logic re;
		logic rxf;
		logic irq_src;
		logic clk_stop;
		logic [7:0] txbuf;
		logic [7:0] rxbuf;
		logic ovr;
		logic select_function_enable;
		logic phase;
		logic role;
		logic err;
		logic [7:0] baud;
		logic halve;
		logic sync_en;
		eng_state_t eng;
		logic [7:0] txsh;
		logic [7:0] rxsh;
		logic [3:0] cnt;
		logic ovr_pend;
		logic [7:0] div;
		logic gen_clk;
		logic half_clk;
		logic prev_ext;
		logic prev_lvl;
		logic prev_trig;
		logic tx_bit;
		logic mtx_oe_n;
		logic stx_oe_n;
		logic sclk_oe_n;
		logic sclk_o;
		logic tx_irq;
		logic rx_irq;
	} core_state_t;

endpackage

// ===== pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync
	import sync_serial_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire pin_in_t pins_raw,
	output var pin_in_t pins_sync
);

	sync_state_t st_reg;
	sync_state_t st_next;

	// idle pin levels: lines high, clock low
	localparam pin_in_t PIN_RST = '{sclk: 1'b0, sel_n: 1'b1, trig_n: 1'b1, mrx: 1'b1, srx: 1'b1};

	// two flip-flop stages, only the second one is visible
	always_comb
	begin
		st_next = st_reg;
		st_next.meta = pins_raw;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '{meta: PIN_RST, stable: PIN_RST};
		else
			st_reg <= st_next;
	end

	assign pins_sync = st_reg.stable;

endmodule
`default_nettype wire

// ===== sync_serial_core.sv
// Functional notes
// - select enable bit turns on select-pin mode
// - role bit one is slave, zero master
// - slave, select high: float pins, ignore clock
// - slave, select low: accept clock and transfer
// - master, select high: drive clock and transfer
// - master, select low: float pins, set fault
// - fault cleared by software only while select high
// - phase and polarity bits give four clockings
// - slave phase zero: output follows clock only
// - slave phase one: first bit at select low
// - external sync frames are exactly eight bits
// - external sync mode takes clock from pin
// - enables plus loaded data, then trigger starts
// - transmit interrupt at load or at completion
// - receive interrupt when frame reaches buffer
// - overrun when seventh bit meets unread buffer
// - overrun raises neither receive flag nor interrupt
// - external clock used direct or halved
// - stop bit halts transfer clock in sync mode
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_defs.svh"

module sync_serial_core
	import sync_serial_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_clock_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe_n,
	input wire logic slave_select_in_n,
	input wire logic trigger_in_pin_n,
	input wire logic master_rx_pin,
	input wire logic slave_rx_pin,
	output logic master_tx_pin_o,
	output logic master_tx_pin_oe_n,
	output logic slave_tx_pin_o,
	output logic slave_tx_pin_oe_n,
	output logic tx_irq,
	output logic rx_irq
);

	localparam core_state_t RST = '{tbe: 1'b1, tx_bit: 1'b1, mtx_oe_n: 1'b1, stx_oe_n: 1'b1,
		sclk_oe_n: 1'b1, prev_trig: 1'b1, eng: ENG_IDLE, default: '0};

	core_state_t st_reg;
	core_state_t st_next;
	pin_in_t pins_raw;
	pin_in_t pins_s;
	logic [3:0] idx;
	logic [31:0] rd_data;
	logic wr_acc;
	logic rd_acc;
	logic active;
	logic slave_m;
	logic ext_m;
	logic sel_hi;
	logic fault_cond;
	logic lvl;
	logic edge_ok;
	logic lead;
	logic trail;
	logic sample;
	logic trig_fall;
	logic start;
	logic rx_bit;
	logic ovr_now;
	logic [3:0] cnt_after;
	logic [7:0] ld;

	// register address to index
	function automatic logic [3:0] reg_index(input logic [7:0] a);
		if (a == `OFF_MODE)
			return `IDX_MODE;
		else if (a == `OFF_CTRL0)
			return `IDX_CTRL0;
		else if (a == `OFF_CTRL1)
			return `IDX_CTRL1;
		else if (a == `OFF_TXBUF)
			return `IDX_TXBUF;
		else if (a == `OFF_RXBUF)
			return `IDX_RXBUF;
		else if (a == `OFF_SMR3)
			return `IDX_SMR3;
		else if (a == `OFF_BAUD)
			return `IDX_BAUD;
		else if (a == `OFF_CLKSYNC)
			return `IDX_CLKSYNC;
		else
			return `IDX_NONE;
	endfunction

	// bit that leaves the shifter next
	function automatic logic out_bit(input logic [7:0] sh, input logic msb);
		return msb ? sh[7] : sh[0];
	endfunction

	function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic msb);
		return msb ? {sh[6:0], 1'b1} : {1'b1, sh[7:1]};
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic msb);
		return msb ? {sh[6:0], b} : {b, sh[7:1]};
	endfunction

	assign pins_raw = '{sclk: serial_clock_pin_i, sel_n: slave_select_in_n,
		trig_n: trigger_in_pin_n, mrx: master_rx_pin, srx: slave_rx_pin};

	pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pins_raw(pins_raw),
		.pins_sync(pins_s)
	);

	// read data for the addressed register
	always_comb
	begin
		idx = reg_index(paddr);
		rd_data = '0;
		if (idx == `IDX_MODE)
			rd_data = {28'h0000000, st_reg.clk_dir, st_reg.mode_sel};
		else if (idx == `IDX_CTRL0)
			rd_data = {24'h000000, st_reg.msb_first, st_reg.pol, 1'b0, st_reg.hs_dis,
				st_reg.eng == ENG_IDLE, 3'h0};
		else if (idx == `IDX_CTRL1)
			rd_data = {26'h0000000, st_reg.clk_stop, st_reg.irq_src, st_reg.rxf,
				st_reg.re, st_reg.tbe, st_reg.te};
		else if (idx == `IDX_TXBUF)
			rd_data = {24'h000000, st_reg.txbuf};
		else if (idx == `IDX_RXBUF)
			rd_data = {19'h00000, st_reg.ovr, 4'h0, st_reg.rxbuf};
		else if (idx == `IDX_SMR3)
			rd_data = {26'h0000000, st_reg.err, 1'b0, st_reg.role, 1'b0,
				st_reg.phase, st_reg.select_function_enable};
		else if (idx == `IDX_BAUD)
			rd_data = {24'h000000, st_reg.baud};
		else if (idx == `IDX_CLKSYNC)
			rd_data = {30'h00000000, st_reg.sync_en, st_reg.halve};
	end

	// bus access, then transfer engine; engine updates follow so a set beats a clear
	always_comb
	begin
		st_next = st_reg;
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;
		st_next.tx_irq = 1'b0;
		st_next.rx_irq = 1'b0;
		wr_acc = psel && penable && st_reg.pready && pwrite;
		rd_acc = psel && penable && st_reg.pready && !pwrite;
		active = st_reg.mode_sel == `MODE_CLKSYNC;
		slave_m = st_reg.select_function_enable ? st_reg.role : st_reg.clk_dir;
		ext_m = !st_reg.select_function_enable && st_reg.clk_dir && (st_reg.halve || st_reg.sync_en);
		sel_hi = pins_s.sel_n;
		fault_cond = active && st_reg.select_function_enable && !st_reg.role && !sel_hi;
		rx_bit = (st_reg.select_function_enable && slave_m) ? pins_s.srx : pins_s.mrx;
		ld = st_reg.tbe ? `IDLE_FILL : st_reg.txbuf;
		// setup phase: answer is prepared for the access phase
		if (psel && !penable)
		begin
			st_next.pready = 1'b1;
			st_next.pslverr = idx == `IDX_NONE;
			st_next.prdata = rd_data;
		end
		// reading the receive buffer releases it
		if (rd_acc && idx == `IDX_RXBUF)
		begin
			st_next.rxf = 1'b0;
			st_next.ovr = 1'b0;
		end
		// register writes
		if (wr_acc)
		begin
			if (idx == `IDX_MODE)
			begin
				st_next.mode_sel = pwdata[`MODE_SEL_LSB +: 3];
				st_next.clk_dir = pwdata[`MODE_CLKDIR_BIT];
			end
			else if (idx == `IDX_CTRL0)
			begin
				st_next.hs_dis = pwdata[`C0_HSDIS_BIT];
				st_next.pol = pwdata[`C0_POL_BIT];
				st_next.msb_first = pwdata[`C0_ORDER_BIT];
			end
			else if (idx == `IDX_CTRL1)
			begin
				st_next.te = pwdata[`C1_TE_BIT];
				st_next.re = pwdata[`C1_RE_BIT];
				st_next.irq_src = pwdata[`C1_IRQSRC_BIT];
				st_next.clk_stop = pwdata[`C1_CLKSTOP_BIT];
			end
			else if (idx == `IDX_TXBUF)
			begin
				st_next.txbuf = pwdata[7:0];
				st_next.tbe = 1'b0;
			end
			else if (idx == `IDX_SMR3)
			begin
				st_next.select_function_enable = pwdata[`S3_SSE_BIT];
				st_next.phase = pwdata[`S3_PHASE_BIT];
				st_next.role = pwdata[`S3_ROLE_BIT];
				if (!pwdata[`S3_ERR_BIT] && sel_hi)
					st_next.err = 1'b0;
			end
			else if (idx == `IDX_BAUD)
				st_next.baud = pwdata[7:0];
			else if (idx == `IDX_CLKSYNC)
			begin
				st_next.halve = pwdata[`CS_HALVE_BIT];
				st_next.sync_en = pwdata[`CS_SYNC_BIT];
			end
		end
		// idle clocks rest at the polarity level, so a start shows no false edge
		if (st_reg.eng == ENG_IDLE)
		begin
			st_next.half_clk = st_reg.pol;
			st_next.gen_clk = st_reg.pol;
		end
		// halved external clock toggles on each rising pin edge
		else if (pins_s.sclk && !st_reg.prev_ext)
			st_next.half_clk = !st_reg.half_clk;
		st_next.prev_ext = pins_s.sclk;
		lvl = slave_m ? ((ext_m && st_reg.halve) ? st_reg.half_clk : pins_s.sclk) : st_reg.gen_clk;
		st_next.prev_lvl = lvl;
		// clock edges count only while running and not gated off
		edge_ok = st_reg.eng == ENG_RUN && lvl != st_reg.prev_lvl
			&& !(st_reg.select_function_enable && slave_m && sel_hi)
			&& !(ext_m && st_reg.clk_stop);
		lead = edge_ok && lvl != st_reg.pol;
		trail = edge_ok && lvl == st_reg.pol;
		sample = st_reg.phase ? lead : trail;
		trig_fall = st_reg.prev_trig && !pins_s.trig_n;
		st_next.prev_trig = pins_s.trig_n;
		// start condition per mode
		start = 1'b0;
		if (st_reg.eng == ENG_IDLE && active && !fault_cond)
		begin
			if (ext_m)
				start = st_reg.te && st_reg.re && !st_reg.tbe && trig_fall;
			else if (!slave_m)
				start = st_reg.te && !st_reg.tbe && !(st_reg.select_function_enable && st_reg.err);
			else if (st_reg.select_function_enable)
				start = !sel_hi && (st_reg.te || st_reg.re);
			else
				start = st_reg.te && !st_reg.tbe;
		end
		ovr_now = sample && st_reg.cnt == `OVR_CHECK_BIT && st_reg.rxf && st_reg.re;
		cnt_after = sample ? st_reg.cnt + 4'h1 : st_reg.cnt;
		if (start)
		begin
			st_next.eng = ENG_RUN;
			st_next.cnt = '0;
			st_next.ovr_pend = 1'b0;
			st_next.txsh = ld;
			st_next.div = '0;
			st_next.gen_clk = st_reg.pol;
			if (!st_reg.tbe)
			begin
				st_next.tbe = 1'b1;
				st_next.tx_irq = !st_reg.irq_src;
			end
			if (st_reg.phase)
				st_next.tx_bit = out_bit(ld, st_reg.msb_first);
		end
		else if (st_reg.eng == ENG_RUN)
		begin
			// master clock generator: half period of baud plus one cycles
			if (!slave_m)
			begin
				if (st_reg.div == st_reg.baud)
				begin
					st_next.div = '0;
					st_next.gen_clk = !st_reg.gen_clk;
				end
				else
					st_next.div = st_reg.div + 8'h01;
			end
			if (lead && !st_reg.phase)
			begin
				st_next.tx_bit = out_bit(st_reg.txsh, st_reg.msb_first);
				st_next.txsh = shift_out(st_reg.txsh, st_reg.msb_first);
			end
			if (sample)
			begin
				st_next.rxsh = shift_in(st_reg.rxsh, rx_bit, st_reg.msb_first);
				st_next.cnt = cnt_after;
				if (ovr_now)
					st_next.ovr_pend = 1'b1;
			end
			if (trail && cnt_after == `FRAME_BITS)
			begin
				st_next.eng = ENG_IDLE;
				st_next.gen_clk = st_reg.pol;
				st_next.tx_irq = st_reg.irq_src;
				if (st_reg.re)
				begin
					st_next.rxbuf = st_next.rxsh;
					if (st_reg.ovr_pend || ovr_now)
						st_next.ovr = 1'b1;
					else
					begin
						st_next.rxf = 1'b1;
						st_next.rx_irq = 1'b1;
					end
				end
			end
			else if (trail && st_reg.phase)
			begin
				st_next.txsh = shift_out(st_reg.txsh, st_reg.msb_first);
				st_next.tx_bit = out_bit(st_next.txsh, st_reg.msb_first);
			end
		end
		// competing master: fault, abort, stop the clock
		if (fault_cond)
		begin
			st_next.err = 1'b1;
			st_next.eng = ENG_IDLE;
			st_next.gen_clk = st_reg.pol;
		end
		// a deselected slave drops its frame, so the next select starts afresh
		if (st_reg.select_function_enable && slave_m && sel_hi)
			st_next.eng = ENG_IDLE;
		if (!active)
			st_next.eng = ENG_IDLE;
		// pin drivers, floated in the cases that forbid driving
		st_next.sclk_o = st_next.gen_clk;
		st_next.sclk_oe_n = !(active && !slave_m && !(st_reg.select_function_enable && st_next.err));
		st_next.mtx_oe_n = !(active && !(st_reg.select_function_enable && slave_m)
			&& !(st_reg.select_function_enable && !slave_m && st_next.err));
		st_next.stx_oe_n = !(active && st_reg.select_function_enable && slave_m && !sel_hi);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= RST;
		else
			st_reg <= st_next;
	end

	// outputs straight from the state flip-flops
	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign serial_clock_pin_o = st_reg.sclk_o;
	assign serial_clock_pin_oe_n = st_reg.sclk_oe_n;
	assign master_tx_pin_o = st_reg.tx_bit;
	assign master_tx_pin_oe_n = st_reg.mtx_oe_n;
	assign slave_tx_pin_o = st_reg.tx_bit;
	assign slave_tx_pin_oe_n = st_reg.stx_oe_n;
	assign tx_irq = st_reg.tx_irq;
	assign rx_irq = st_reg.rx_irq;

	// checks on the engine and the pins
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	fault_set_a: assert property (fault_cond |=> st_reg.err && st_reg.eng == ENG_IDLE)
		else $error("fault flag not set for competing master");
	fault_float_a: assert property (st_reg.err && st_reg.select_function_enable && !st_reg.role ##1 st_reg.err
		|-> master_tx_pin_oe_n && serial_clock_pin_oe_n)
		else $error("master pins driven during fault");
	slave_float_a: assert property (active && st_reg.select_function_enable && st_reg.role && sel_hi
		|=> slave_tx_pin_oe_n)
		else $error("slave output driven while select high");
	phase_one_a: assert property (start && st_reg.select_function_enable && slave_m && st_reg.phase
		|=> !slave_tx_pin_oe_n && slave_tx_pin_o == out_bit($past(ld), st_reg.msb_first))
		else $error("first bit missing at select low");
	frame_len_a: assert property ($fell(st_reg.eng == ENG_RUN) && !$past(fault_cond)
		&& $past(active) && !$past(st_reg.select_function_enable && slave_m && sel_hi)
		|-> $past(st_reg.cnt) == `FRAME_BITS - 4'h1 || $past(st_reg.cnt) == `FRAME_BITS)
		else $error("frame ended at wrong bit count");
	tx_irq_load_a: assert property (start && !st_reg.tbe && !st_reg.irq_src
		|=> tx_irq && st_reg.tbe)
		else $error("load interrupt missing");
	overrun_a: assert property (sample && st_reg.cnt == `OVR_CHECK_BIT && st_reg.rxf
		&& st_reg.re |=> st_reg.ovr_pend)
		else $error("overrun not detected at seventh bit");
	rx_done_a: assert property (rx_irq |-> st_reg.rxf && !st_reg.ovr_pend
		&& $past(st_reg.eng) == ENG_RUN)
		else $error("receive interrupt without clean frame");
	ovr_noflag_a: assert property ($rose(st_reg.ovr) |-> !rx_irq && !$rose(st_reg.rxf))
		else $error("receive interrupt raised on overrun");
	clk_stop_a: assert property (ext_m && st_reg.clk_stop && st_reg.eng == ENG_RUN
		|=> st_reg.cnt == $past(st_reg.cnt))
		else $error("bits moved while transfer clock stopped");

endmodule
`default_nettype wire

// ===== sync_serial_peer.sv
`timescale 1ns/1ps
`default_nettype none

module sync_serial_peer
(
	input wire logic pclk,
	input wire logic sclk_in,
	input wire logic din,
	output logic sclk_out,
	output logic sel_n,
	output logic trig_n,
	output logic dout
);
	logic busy;

	// idle levels; the clock stands still between frames
	initial
	begin
		busy = 1'b0;
		dout = 1'b0;
		sclk_out = 1'b0;
		sel_n = 1'b1;
		trig_n = 1'b1;
	end

	// a released data line keeps changing so no stale bit passes for data
	always @(posedge pclk)
	begin
		if (!busy)
			dout <= ~dout;
	end

	// one lsb-first frame; drive makes the clock here, else the device clock is followed
	task automatic xfer(input logic [7:0] tx, input logic pol, input logic ph,
		input logic drive, input logic use_sel, input int half, output logic [7:0] rx);
		int k;
		int n;
		logic prv;
		busy = 1'b1;
		rx = 8'h00;
		k = 0;
		n = 0;
		prv = pol;
		@(posedge pclk);
		sclk_out <= pol;
		if (ph)
			dout <= tx[0];
		if (drive)
		begin
			repeat (half) @(posedge pclk);
			sel_n <= !use_sel;
			trig_n <= use_sel; // start pulse on the trigger line
		end
		while (k < 16 && n < 6000)
		begin
			@(posedge pclk);
			n++;
			trig_n <= 1'b1;
			if (drive && n % half == 0)
				sclk_out <= ~sclk_out;
			if (sclk_in !== prv)
			begin
				prv = sclk_in;
				if (k % 2 != ph) // same polarity and phase as the device
					rx[k / 2] = din;
				else if ((k + 1) / 2 < 8)
					dout <= tx[(k + 1) / 2];
				k++;
			end
		end
		repeat (half) @(posedge pclk);
		sel_n <= 1'b1;
		busy = 1'b0;
	endtask
endmodule

`default_nettype wire

// ===== sync_serial_select_and_clock_sync_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_defs.svh"

`define CHK(got, exp) \
begin \
	checks_done++; \
	if ((got) !== (exp)) \
	begin \
		fails++; \
		$display("[FAIL] %0t got %h want %h", $time, (got), (exp)); \
	end \
end

module sync_serial_select_and_clock_sync_tb;
	logic pclk;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, flt = 1'b0, tb_sel_n = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, sclk_o, sclk_oe_n, mtx_o, mtx_oe_n, stx_o, stx_oe_n;
	logic tx_irq, rx_irq, p_sclk, p_sel_n, p_trig_n, p_dout, sclk_w, sel_w, tx_w;
	logic [7:0] d, p, q;
	int fails = 0, checks_done = 0, ntx = 0, nrx = 0, seed, i, tx0, rx0;

	// resolve shared lines; an undriven data line toggles every cycle
	assign sclk_w = !sclk_oe_n ? sclk_o : p_sclk;
	assign sel_w = p_sel_n & tb_sel_n;
	assign tx_w = !mtx_oe_n ? mtx_o : (!stx_oe_n ? stx_o : flt);

	sync_serial_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sclk_o),
		.serial_clock_pin_oe_n(sclk_oe_n), .slave_select_in_n(sel_w),
		.trigger_in_pin_n(p_trig_n), .master_rx_pin(p_dout), .slave_rx_pin(p_dout),
		.master_tx_pin_o(mtx_o), .master_tx_pin_oe_n(mtx_oe_n), .slave_tx_pin_o(stx_o),
		.slave_tx_pin_oe_n(stx_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq));

	sync_serial_peer u_peer (.pclk(pclk), .sclk_in(sclk_w), .din(tx_w), .sclk_out(p_sclk),
		.sel_n(p_sel_n), .trig_n(p_trig_n), .dout(p_dout));

	// clock
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// interrupt pulse counters and float pattern
	always @(posedge pclk)
	begin
		flt <= ~flt;
		if (tx_irq === 1'b1)
			ntx <= ntx + 1;
		if (rx_irq === 1'b1)
			nrx <= nrx + 1;
	end

	// one apb transfer, entered and left just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20)
			fails++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// bounded wait for a receive interrupt count
	task automatic wait_rx(input int n);
		int c;
		c = 0;
		while (nrx < n && c < 400)
		begin
			@(posedge pclk);
			c++;
		end
	endtask

	task automatic results();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// cut a hang short
	initial
	begin
		repeat (30000) @(posedge pclk);
		fails++;
		results();
	end

	// main sequence
	initial
	begin
		seed = 32'hD02B;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `OFF_CTRL1, 32'h0);
		`CHK(rd, 32'h00000002)
		apb(1'b0, 8'h20, 32'h0);
		`CHK({err, rd}, 33'h100000000)
		// master frames in all four clockings, completion interrupt
		apb(1'b1, `OFF_MODE, 32'h1);
		apb(1'b1, `OFF_BAUD, 32'h8);
		for (i = 0; i < 4; i++)
		begin
			{d, p} = 16'($random(seed));
			apb(1'b1, `OFF_CTRL0, 32'(i[0]) << `C0_POL_BIT);
			apb(1'b1, `OFF_SMR3, 32'h1 | (32'(i[1]) << `S3_PHASE_BIT));
			apb(1'b1, `OFF_CTRL1, 32'h15);
			tx0 = ntx;
			rx0 = nrx;
			fork
				apb(1'b1, `OFF_TXBUF, 32'(d));
				u_peer.xfer(p, i[0], i[1], 1'b0, 1'b0, 8, q);
			join
			wait_rx(rx0 + 1);
			`CHK(q, d)
			`CHK(ntx - tx0, 1)
			apb(1'b0, `OFF_RXBUF, 32'h0);
			`CHK(rd[7:0], p)
		end
		// competing master: fault, sticky until cleared with select high
		tb_sel_n <= 1'b0;
		repeat (6) @(posedge pclk);
		`CHK({sclk_oe_n, mtx_oe_n}, 2'b11)
		apb(1'b1, `OFF_SMR3, 32'h1);
		apb(1'b0, `OFF_SMR3, 32'h0);
		`CHK(rd[`S3_ERR_BIT], 1'b1)
		tb_sel_n <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK({sclk_oe_n, mtx_oe_n}, 2'b11)
		apb(1'b0, `OFF_SMR3, 32'h0);
		`CHK(rd[`S3_ERR_BIT], 1'b1)
		apb(1'b1, `OFF_SMR3, 32'h1);
		repeat (4) @(posedge pclk);
		`CHK(sclk_oe_n, 1'b0)
		// slave behind the select line: ignored while high, both phases when low
		for (i = 0; i < 2; i++)
		begin
			{d, p} = 16'($random(seed));
			apb(1'b1, `OFF_CTRL0, 32'(i) << `C0_POL_BIT);
			apb(1'b1, `OFF_SMR3, 32'h9 | (32'(i) << `S3_PHASE_BIT));
			apb(1'b1, `OFF_TXBUF, 32'(d));
			rx0 = nrx;
			u_peer.xfer(p, i[0], i[0], 1'b1, 1'b0, 8, q);
			`CHK({stx_oe_n, 32'(nrx - rx0)}, 33'h100000000)
			fork
				u_peer.xfer(p, i[0], i[0], 1'b1, 1'b1, 8, q);
				begin
					repeat (15) @(posedge pclk);
					if (i == 1)
						`CHK({stx_oe_n, stx_o}, {1'b0, d[0]})
				end
			join
			wait_rx(rx0 + 1);
			`CHK(q, d)
			apb(1'b0, `OFF_RXBUF, 32'h0);
			`CHK(rd[7:0], p)
		end
		// external clock sync mode: trigger-started frames, overrun on the third
		apb(1'b1, `OFF_SMR3, 32'h0);
		apb(1'b1, `OFF_BAUD, 32'h0);
		apb(1'b1, `OFF_MODE, 32'h9);
		apb(1'b1, `OFF_CTRL0, 32'h10);
		apb(1'b1, `OFF_CLKSYNC, 32'h2);
		apb(1'b1, `OFF_CTRL1, 32'h5);
		for (i = 0; i < 3; i++)
		begin
			{d, p} = 16'($random(seed));
			apb(1'b1, `OFF_TXBUF, 32'(d));
			tx0 = ntx;
			rx0 = nrx;
			u_peer.xfer(p, 1'b0, 1'b0, 1'b1, 1'b0, 8, q);
			wait_rx(rx0 + 1);
			`CHK(q, d)
			`CHK(ntx - tx0, 1)
			`CHK(nrx - rx0, (i < 2) ? 1 : 0)
			if (i == 0)
			begin
				apb(1'b0, `OFF_RXBUF, 32'h0);
				`CHK(rd[12:0], 13'(p))
			end
		end
		apb(1'b0, `OFF_RXBUF, 32'h0);
		`CHK(rd[`RB_OVR_BIT], 1'b1)
		// halved transfer clock: one frame needs two bursts of pin clock
		apb(1'b1, `OFF_CLKSYNC, 32'h1);
		apb(1'b1, `OFF_TXBUF, 32'h5A);
		rx0 = nrx;
		u_peer.xfer(8'hC3, 1'b0, 1'b0, 1'b1, 1'b0, 8, q);
		repeat (20) @(posedge pclk);
		`CHK(nrx - rx0, 0)
		u_peer.xfer(8'hC3, 1'b0, 1'b0, 1'b1, 1'b0, 8, q);
		wait_rx(rx0 + 1);
		`CHK(nrx - rx0, 1)
		// stopped transfer clock: edges pass unseen
		apb(1'b1, `OFF_CTRL1, 32'h25);
		apb(1'b1, `OFF_TXBUF, 32'h3C);
		rx0 = nrx;
		u_peer.xfer(8'hA5, 1'b0, 1'b0, 1'b1, 1'b0, 8, q);
		repeat (20) @(posedge pclk);
		`CHK(nrx - rx0, 0)
		results();
	end
endmodule

`default_nettype wire
